// ---- hdl/gedc_top.sv ----
/*
 gedc_top.sv: classic wishbone slave for a 50 pin GPIO port in two banks,
 with edge detect enables, sticky edge status and bitwise set/clear ports.
 assumes: single clock, synchronous reset, pins asynchronous to clk_i.
*/
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`include "gedc_map.svh"
module gedc_top
   import gedc_pkg::*;
#(
   parameter int B0_W = `GEDC_BANK0_W,
   parameter int B1_W = `GEDC_BANK1_W
) (
   input wire logic clk_i,               // peripheral clock, 50 MHz
   input wire logic rst_i,               // synchronous reset, high
   input wire logic wb_cyc_i,            // wishbone cycle
   input wire logic wb_stb_i,            // wishbone strobe
   input wire logic wb_we_i,             // write enable
   input wire logic [7:0] wb_adr_i,      // byte address
   input wire logic [3:0] wb_sel_i,      // byte lanes
   input wire logic [31:0] wb_dat_i,     // write data
   output logic [31:0] wb_dat_o,         // read data, registered
   output logic wb_ack_o,                // acknowledge
   input wire logic [B0_W-1:0] pin0_i,   // bank 0 pin levels
   input wire logic [B1_W-1:0] pin1_i,   // bank 1 pin levels
   output logic [B0_W-1:0] dir0_o,       // bank 0 direction, 1 output
   output logic [B1_W-1:0] dir1_o        // bank 1 direction, 1 output
);
   gedc_bus_state_t st_q, st_d;
   logic [31:0] rd_q, rd_d, wmask, wdat;
   gedc_op_t op;
   logic sel1, hit;

   gedc_bank_if #(.W(B0_W)) bi0 ();
   gedc_bank_if #(.W(B1_W)) bi1 ();

   // refuse widths that the fixed 32-bit lanes and the decode cannot serve
   if (B0_W != `GEDC_BANK0_W || B1_W > `GEDC_BANK1_W || B1_W < 1) begin : g_bad_width
      $error("bank widths not supported");
   end

   // byte lanes gate the write data; unselected lanes write as zero,
   // which for set, clear and w1c ports means no change
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
      end
   end

   // address decode into one operation and a bank select
   always_comb begin
      op = GEDC_OP_NONE;
      sel1 = 1'b0;
      hit = 1'b1;
      case (wb_adr_i)
         `GEDC_OFS_DIR0: op = GEDC_OP_DIR;
         `GEDC_OFS_DIR1: begin op = GEDC_OP_DIR; sel1 = 1'b1; end
         `GEDC_OFS_RISE0: op = GEDC_OP_RISE;
         `GEDC_OFS_RISE1: begin op = GEDC_OP_RISE; sel1 = 1'b1; end
         `GEDC_OFS_FALL0: op = GEDC_OP_FALL;
         `GEDC_OFS_FALL1: begin op = GEDC_OP_FALL; sel1 = 1'b1; end
         `GEDC_OFS_STAT0: op = GEDC_OP_STAT;
         `GEDC_OFS_STAT1: begin op = GEDC_OP_STAT; sel1 = 1'b1; end
         `GEDC_OFS_DSET0: op = GEDC_OP_DSET;
         `GEDC_OFS_DSET1: begin op = GEDC_OP_DSET; sel1 = 1'b1; end
         `GEDC_OFS_DCLR0: op = GEDC_OP_DCLR;
         `GEDC_OFS_DCLR1: begin op = GEDC_OP_DCLR; sel1 = 1'b1; end
         `GEDC_OFS_RSET0: op = GEDC_OP_RSET;
         `GEDC_OFS_RSET1: begin op = GEDC_OP_RSET; sel1 = 1'b1; end
         `GEDC_OFS_RCLR0: op = GEDC_OP_RCLR;
         `GEDC_OFS_RCLR1: begin op = GEDC_OP_RCLR; sel1 = 1'b1; end
         `GEDC_OFS_FSET0: op = GEDC_OP_FSET;
         `GEDC_OFS_FSET1: begin op = GEDC_OP_FSET; sel1 = 1'b1; end
         `GEDC_OFS_FCLR0: op = GEDC_OP_FCLR;
         `GEDC_OFS_FCLR1: begin op = GEDC_OP_FCLR; sel1 = 1'b1; end
         default: hit = 1'b0;
      endcase
   end

   // commit a write only in the idle cycle before the ack goes out, so each write
   // strobes exactly once even though the master holds the request
   always_comb begin
      wdat = wb_dat_i & wmask;
      bi0.op = GEDC_OP_NONE;
      bi1.op = GEDC_OP_NONE;
      if (st_q == GEDC_IDLE && wb_cyc_i && wb_stb_i && wb_we_i && hit) begin
         if (sel1) begin
            bi1.op = op;
         end else begin
            bi0.op = op;
         end
      end
      bi0.wdata = wdat[B0_W-1:0];
      bi1.wdata = wdat[B1_W-1:0];
      bi0.pins = pin0_i;
      bi1.pins = pin1_i;
   end

   // read mux; write-only ports and unmapped addresses read zero
   always_comb begin
      rd_d = `GEDC_RST_VAL;
      case (wb_adr_i)
         `GEDC_OFS_DIR0: rd_d = 32'(bi0.dir);
         `GEDC_OFS_DIR1: rd_d = 32'(bi1.dir);
         `GEDC_OFS_RISE0: rd_d = 32'(bi0.rise_en);
         `GEDC_OFS_RISE1: rd_d = 32'(bi1.rise_en);
         `GEDC_OFS_FALL0: rd_d = 32'(bi0.fall_en);
         `GEDC_OFS_FALL1: rd_d = 32'(bi1.fall_en);
         `GEDC_OFS_STAT0: rd_d = 32'(bi0.status);
         `GEDC_OFS_STAT1: rd_d = 32'(bi1.status);
         default: rd_d = `GEDC_RST_VAL;
      endcase
   end

   // one-wait-state slave: ack one cycle after strobe, drop it next cycle
   always_comb begin
      st_d = GEDC_IDLE;
      case (st_q)
         GEDC_IDLE: if (wb_cyc_i && wb_stb_i) st_d = GEDC_ACK;
         GEDC_ACK: st_d = GEDC_IDLE;
         default: st_d = GEDC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= GEDC_IDLE;
         rd_q <= `GEDC_RST_VAL;
      end else begin
         st_q <= st_d;
         rd_q <= rd_d;
      end
   end

   gedc_bank #(.W(B0_W)) u_bank0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .b(bi0)
   );

   gedc_bank #(.W(B1_W)) u_bank1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .b(bi1)
   );

   assign wb_ack_o = (st_q == GEDC_ACK);
   assign wb_dat_o = rd_q;
   assign dir0_o = bi0.dir;
   assign dir1_o = bi1.dir;
endmodule

// ---- hdl/gedc_map.svh ----
/*
 gedc_map.svh: register offsets, bank widths and reset values of the GPIO
 edge detect and direction block.
 assumes: included by bare name from the package and the top module.
*/
`ifndef GEDC_MAP_SVH
`define GEDC_MAP_SVH

`define GEDC_OFS_DIR0      8'h0c
`define GEDC_OFS_DIR1      8'h10
`define GEDC_OFS_RISE0     8'h30
`define GEDC_OFS_RISE1     8'h34
`define GEDC_OFS_FALL0     8'h3c
`define GEDC_OFS_FALL1     8'h40
`define GEDC_OFS_STAT0     8'h48
`define GEDC_OFS_STAT1     8'h4c
`define GEDC_OFS_DSET0     8'h54
`define GEDC_OFS_DSET1     8'h58
`define GEDC_OFS_DCLR0     8'h60
`define GEDC_OFS_DCLR1     8'h64
`define GEDC_OFS_RSET0     8'h6c
`define GEDC_OFS_RSET1     8'h70
`define GEDC_OFS_RCLR0     8'h78
`define GEDC_OFS_RCLR1     8'h7c
`define GEDC_OFS_FSET0     8'h84
`define GEDC_OFS_FSET1     8'h88
`define GEDC_OFS_FCLR0     8'h90
`define GEDC_OFS_FCLR1     8'h94
`define GEDC_ADDR_W        8
`define GEDC_BANK0_W       32
`define GEDC_BANK1_W       18
`define GEDC_RST_VAL       32'h0000_0000
`define GEDC_SYNC_STAGES   2

`endif

// ---- hdl/gedc_pkg.sv ----
/*
 gedc_pkg.sv: shared types of the GPIO edge detect and direction block.
 assumes: gedc_map.svh is on the include path.
*/
package gedc_pkg;
`include "gedc_map.svh"
   typedef logic [31:0] gedc_word_t;
   // bus slave states, gray coded along idle -> ack
   typedef enum logic [0:0] {
      GEDC_IDLE = 1'b0,
      GEDC_ACK = 1'b1
   } gedc_bus_state_t;
   // per-bank write strobes decoded from the bus
   typedef enum logic [3:0] {
      GEDC_OP_NONE = 4'h0,
      GEDC_OP_DIR = 4'h1,
      GEDC_OP_RISE = 4'h2,
      GEDC_OP_FALL = 4'h3,
      GEDC_OP_STAT = 4'h4,
      GEDC_OP_DSET = 4'h5,
      GEDC_OP_DCLR = 4'h6,
      GEDC_OP_RSET = 4'h7,
      GEDC_OP_RCLR = 4'h8,
      GEDC_OP_FSET = 4'h9,
      GEDC_OP_FCLR = 4'ha
   } gedc_op_t;
endpackage

// ---- hdl/gedc_bank_if.sv ----
/*
 gedc_bank_if.sv: carries one bank's write command and state between the
 top and a bank instance.
 assumes: one clock; the top drives the command side.
*/
`timescale 1ns/10ps
interface gedc_bank_if #(parameter int W = 32);
   import gedc_pkg::*;
   gedc_op_t op;
   logic [W-1:0] wdata;
   logic [W-1:0] pins;
   logic [W-1:0] dir;
   logic [W-1:0] rise_en;
   logic [W-1:0] fall_en;
   logic [W-1:0] status;
   modport ctrl (output op, output wdata, output pins,
                 input dir, input rise_en, input fall_en, input status);
   modport bank (input op, input wdata, input pins,
                 output dir, output rise_en, output fall_en, output status);
endinterface

// ---- hdl/gedc_bank.sv ----
/*
 gedc_bank.sv: one GPIO bank: direction, edge enables, synchroniser,
 edge detector and sticky status.
 assumes: op is a one-cycle write strobe with wdata; pins are asynchronous.
*/
`timescale 1ns/10ps
module gedc_bank
   import gedc_pkg::*;
#(
   parameter int W = 32
) (
   input wire logic clk_i, // peripheral clock
   input wire logic rst_i, // synchronous reset, high
   gedc_bank_if.bank b     // command and state
);
   logic [W-1:0] dir_q, dir_d, rise_q, rise_d, fall_q, fall_d, stat_q, stat_d;
   logic [W-1:0] s1_q, s2_q, s3_q, edge_hit;

   // a bank wider than the bus word could never be written whole
   if (W < 1 || W > 32) begin : g_bad_width
      $error("bank width out of range");
   end

   // detect on synchronised samples; s3 is the previous level
   always_comb begin
      edge_hit = (rise_q & s2_q & ~s3_q)
               | (fall_q & ~s2_q & s3_q);
   end

   // write side effects; the new edge is or-ed after the clear so it wins
   always_comb begin
      dir_d = dir_q;
      rise_d = rise_q;
      fall_d = fall_q;
      stat_d = stat_q;
      case (b.op)
         GEDC_OP_DIR: dir_d = b.wdata;
         GEDC_OP_RISE: rise_d = b.wdata;
         GEDC_OP_FALL: fall_d = b.wdata;
         GEDC_OP_STAT: stat_d = stat_q & ~b.wdata;
         GEDC_OP_DSET: dir_d = dir_q | b.wdata;
         GEDC_OP_DCLR: dir_d = dir_q & ~b.wdata;
         GEDC_OP_RSET: rise_d = rise_q | b.wdata;
         GEDC_OP_RCLR: rise_d = rise_q & ~b.wdata;
         GEDC_OP_FSET: fall_d = fall_q | b.wdata;
         GEDC_OP_FCLR: fall_d = fall_q & ~b.wdata;
         default: ;
      endcase
      stat_d = stat_d | edge_hit;
   end

   // registers; first sync stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= '0;
         rise_q <= '0;
         fall_q <= '0;
         stat_q <= '0;
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         dir_q <= dir_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         stat_q <= stat_d;
         s1_q <= b.pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign b.dir = dir_q;
   assign b.rise_en = rise_q;
   assign b.fall_en = fall_q;
   assign b.status = stat_q;
endmodule

// ---- tb/gedc_asserts.sv ----
/*
 gedc_asserts.sv: port checker for gedc_top, bound at the foot of the file.
 assumes: one clock; writes use all byte lanes; master drops cyc after ack.
*/
`timescale 1ns/10ps
module gedc_asserts #(
   parameter int B0_W = 32,
   parameter int B1_W = 18
) (
   input wire logic clk_i,             // clock
   input wire logic rst_i,             // reset
   input wire logic wb_cyc_i,          // cycle
   input wire logic wb_stb_i,          // strobe
   input wire logic wb_we_i,           // write
   input wire logic [7:0] wb_adr_i,    // address
   input wire logic [3:0] wb_sel_i,    // lanes
   input wire logic [31:0] wb_dat_i,   // write data
   input wire logic [31:0] wb_dat_o,   // read data
   input wire logic wb_ack_o,          // ack
   input wire logic [B0_W-1:0] pin0_i, // pins 0
   input wire logic [B1_W-1:0] pin1_i, // pins 1
   input wire logic [B0_W-1:0] dir0_o, // dir 0
   input wire logic [B1_W-1:0] dir1_o  // dir 1
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request that the idle slave will take
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // the ack cycle of a full-word write to one address
   sequence s_wr(a);
      wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == a;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without request");
   a_dset_bank0: assert property (s_wr(8'h54) |-> dir0_o == ($past(dir0_o) | wb_dat_i))
      else $error("direction set bank 0 wrong");
   a_dclr_bank0: assert property (s_wr(8'h60) |-> dir0_o == ($past(dir0_o) & ~wb_dat_i))
      else $error("direction clear bank 0 wrong");
   a_dset_bank1: assert property (s_wr(8'h58)
      |-> dir1_o == ($past(dir1_o) | wb_dat_i[17:0]))
      else $error("direction set bank 1 wrong");
   // direction only moves in the ack cycle of a write
   a_dir_hold: assert property (!wb_ack_o |-> $stable(dir0_o) && $stable(dir1_o))
      else $error("direction moved without a write");
   a_wo_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {8'h54, 8'h64, 8'h70}
      |-> wb_dat_o == 32'h0)
      else $error("write-only port read non-zero");
   a_bank1_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {8'h10, 8'h34, 8'h4c}
      |-> wb_dat_o[31:18] == 14'h0)
      else $error("bank 1 reserved bits read non-zero");
endmodule

bind gedc_top gedc_asserts #(.B0_W(B0_W), .B1_W(B1_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pin0_i(pin0_i), .pin1_i(pin1_i), .dir0_o(dir0_o), .dir1_o(dir1_o));

// ---- tb/gedc_pins.sv ----
/*
 gedc_pins.sv: board side of the port, drives the pin levels.
 assumes: wanted levels come from the bench; pins are unrelated to the clock.
*/
`timescale 1ns/10ps
module gedc_pins (
   input wire logic [31:0] lvl0_i, // wanted bank 0 levels
   input wire logic [17:0] lvl1_i, // wanted bank 1 levels
   output logic [31:0] pin0_o,     // bank 0 pins
   output logic [17:0] pin1_o      // bank 1 pins
);
   // 7 ns lag keeps pin edges away from the sampling edge
   assign #7 pin0_o = lvl0_i;
   assign #7 pin1_o = lvl1_i;
endmodule

// ---- tb/gedc_top_test.sv ----
/*
 gedc_top_test.sv: self-checking bench for gedc_top.
 assumes: checker bound from its own file; board model in gedc_pins.
*/
`timescale 1ns/10ps
module gedc_top_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h0, o;
   logic [31:0] wdat = 32'h0, rdat, dir0, pin0, msk, re, fe, p, r, m;
   logic [17:0] dir1, pin1;
   logic [31:0] lv [2] = '{32'h0, 32'h0};
   logic [31:0] exp_q [$];
   logic [7:0] offs [14] = '{8'h0c, 8'h10, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h48, 8'h4c,
      8'h54, 8'h60, 8'h6c, 8'h78, 8'h90, 8'hfc};
   int bad_count = 0, num_checks = 0, ticks = 0;
   always #10 clk_i = ~clk_i;
   gedc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pin0_i(pin0), .pin1_i(pin1), .dir0_o(dir0), .dir1_o(dir1));
   gedc_pins PINS (.lvl0_i(lv[0]), .lvl1_i(lv[1][17:0]), .pin0_o(pin0), .pin1_o(pin1));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] e, logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   // one classic cycle: hold everything until ack is sampled high
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   // watcher: each read answer meets the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         check($sformatf("read %h", adr), exp_q.pop_front(), rdat);
      end
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 5000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(70165));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, write-only ports and a hole all read zero
      foreach (offs[i]) rd(offs[i], 32'h0);
      for (int b = 0; b < 2; b++) begin
         msk = b ? 32'h0003_ffff : 32'hffff_ffff;
         o = b ? 8'h04 : 8'h00;
         // reserved bank 1 bits are always written as zero
         r = $urandom() & msk;
         m = $urandom() & msk;
         bus(1'b1, 8'h54 + o, r);
         bus(1'b1, 8'h60 + o, m);
         rd(8'h0c + o, r & ~m & msk);
         check("dir port", r & ~m & msk, b ? {14'h0, dir1} : dir0);
         bus(1'b1, 8'h0c + o, ~r & msk);
         rd(8'h0c + o, ~r & msk);
         check("dir plain", ~r & msk, b ? {14'h0, dir1} : dir0);
         re = ($urandom() | 32'h1) & msk;
         fe = ($urandom() | 32'h2) & msk;
         bus(1'b1, 8'h6c + o, re);
         bus(1'b1, 8'h78 + o, m & 32'hffff_fffe);
         bus(1'b1, 8'h84 + o, fe);
         bus(1'b1, 8'h90 + o, m & 32'hffff_fffd);
         re = re & ~(m & 32'hffff_fffe) & msk;
         fe = fe & ~(m & 32'hffff_fffd) & msk;
         rd(8'h30 + o, re);
         rd(8'h3c + o, fe);
         // rising edges on a random set of pins, bit 0 always among them
         p = ($urandom() | 32'h3) & msk;
         lv[b] <= p;
         repeat (5) @(posedge clk_i);
         rd(8'h48 + o, p & re);
         bus(1'b1, 8'h48 + o, msk);
         rd(8'h48 + o, 32'h0);
         lv[b] <= 32'h0;
         repeat (5) @(posedge clk_i);
         rd(8'h48 + o, p & fe);
         bus(1'b1, 8'h48 + o, r & msk);
         rd(8'h48 + o, p & fe & ~r);
         // pins rise so that the edge lands in the cycle the clear-all commits
         lv[b] <= p;
         @(posedge clk_i);
         bus(1'b1, 8'h48 + o, msk);
         rd(8'h48 + o, p & re);
         // plain writes to the enable registers, pins steady
         bus(1'b1, 8'h30 + o, r);
         rd(8'h30 + o, r);
         bus(1'b1, 8'h3c + o, m);
         rd(8'h3c + o, m);
      end
      repeat (2) @(posedge clk_i);
      wrap_up();
   end
endmodule
